// ==== src/request_filter_regs.svh ====
// register offsets, field positions, reset values and widths of the request node filter
`ifndef REQUEST_FILTER_REGS_SVH
`define REQUEST_FILTER_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ASYNC_LOW_SET_OFS   12'h108
`define ASYNC_LOW_CLR_OFS   12'h10c
`define PHYS_HIGH_SET_OFS   12'h110
`define PHYS_HIGH_CLR_OFS   12'h114
`define REQ_STATS_OFS       12'h1f0
`define LAST_REQ_OFS        12'h1f4
`define BUS_NUMBER_OFS      12'h1f8

// ----------------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------------
`define FILTER_RESET        32'h0000_0000
`define REMOTE_BUSES_BIT    31
`define KEEP_ON_BUS_RESET   32'h8000_0000
`define LOCAL_BUS_ALIAS     10'h3ff
`define BUS_NUMBER_RESET    10'h3ff
`define BROADCAST_NODE      6'h3f
`define STAT_CNT_W          8
`define STAT_CNT_MAX        8'hff
`define STAT_CNT_ONE        8'h01
`define STAT_CNT_ZERO       8'h00

`endif

// ==== src/request_filter_pkg.sv ====
// types shared by the request node filter modules
package request_filter_pkg;

    typedef enum logic [1:0] {
        ROUTE_DROP  = 2'b00,
        ROUTE_ASYNC = 2'b01,
        ROUTE_PHYS  = 2'b10
    } route_t;

    typedef logic [5:0] node_id_t;
    typedef logic [9:0] bus_id_t;

endpackage

// ==== src/rsc_filter_reg.sv ====
// one read/set/clear filter word with bits that may survive the bus reset
`timescale 1ns/1ps
`default_nettype none

module rsc_filter_reg #(
    parameter int unsigned      WIDTH     = 32,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter logic [WIDTH-1:0] KEEP_MASK = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             por_n,
    input  wire logic             set_we,
    input  wire logic             clr_we,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] value
);

    logic [WIDTH-1:0] bus_part_ff;
    logic [WIDTH-1:0] keep_part_ff;
    logic [WIDTH-1:0] cur_value;
    logic [WIDTH-1:0] nxt_value;

    // ----------------------------------------------------------------------------
    // set and clear aliases
    // ----------------------------------------------------------------------------
    assign cur_value = (bus_part_ff & ~KEEP_MASK) | (keep_part_ff & KEEP_MASK);
    assign nxt_value = set_we ? (cur_value | wdata) :          // RQ17
                       clr_we ? (cur_value & ~wdata) :         // RQ17
                       cur_value;
    assign value     = cur_value;

    // ----------------------------------------------------------------------------
    // storage: kept bits answer only to power-on reset
    // ----------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_part_ff <= RESET_VAL & ~KEEP_MASK;             // RQ5
        end else begin
            bus_part_ff <= nxt_value & ~KEEP_MASK;
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            keep_part_ff <= RESET_VAL & KEEP_MASK;             // RQ12
        end else begin
            keep_part_ff <= nxt_value & KEEP_MASK;
        end
    end

endmodule

`default_nettype wire

// ==== src/node_filter_decide.sv ====
// combinational accept and routing decision for one incoming request
`timescale 1ns/1ps
`default_nettype none

`include "request_filter_regs.svh"

module node_filter_decide
    import request_filter_pkg::*;
(
    input  wire logic [31:0] async_low,
    input  wire logic [31:0] async_high,
    input  wire logic [31:0] phys_low,
    input  wire logic [31:0] phys_high,
    input  wire bus_id_t     src_bus,
    input  wire node_id_t    src_node,
    input  wire bus_id_t     local_bus,
    input  wire logic        is_phys,
    output route_t           route,
    output logic             is_local,
    output logic             ack
);

    // node 63 is broadcast and owns no filter bit; only the top bit of the physical high word is read, as the remote bit
    function automatic logic node_bit(input logic [31:0] low, input logic [31:0] high,
                                      input node_id_t node);
        logic [4:0] idx;
        idx = node[4:0];
        if (node == `BROADCAST_NODE) begin
            node_bit = 1'b0;
        end else if (node[5]) begin
            node_bit = high[idx];                              // RQ13 RQ15 RQ16
        end else begin
            node_bit = low[idx];                               // RQ2
        end
    endfunction

    logic async_ok;
    logic phys_ok;
    logic remote_all;

    // ----------------------------------------------------------------------------
    // local versus remote source
    // ----------------------------------------------------------------------------
    assign is_local   = (src_bus == `LOCAL_BUS_ALIAS) || (src_bus == local_bus);
    assign remote_all = phys_high[`REMOTE_BUSES_BIT];          // RQ10 RQ11

    // node comparison is only made for local sources
    assign async_ok = is_local ? node_bit(async_low, async_high, src_node) : remote_all;  // RQ1 RQ9 RQ4
    assign phys_ok  = is_local ? node_bit(phys_low, phys_high, src_node) : remote_all;    // RQ6 RQ7

    assign ack   = async_ok;                                   // RQ10
    assign route = !async_ok ? ROUTE_DROP :
                   (is_phys && phys_ok) ? ROUTE_PHYS :          // RQ7
                   ROUTE_ASYNC;                                // RQ8

endmodule

`default_nettype wire

// ==== src/request_node_filter.sv ====
// apb register slave and per-node request filter for incoming bus requests
//
// Summary of operation
// RQ1: a 32-bit asynchronous filter enables requests from each low local node.
// RQ2: bit n of the low asynchronous filter accepts requests from node n.
// RQ3: low asynchronous filter has readable set alias 108h and clear alias 10ch.
// RQ4: low asynchronous filter behaves like the high one, other nodes only.
// RQ5: both filters reset to all zeros, every node disabled.
// RQ6: a 32-bit physical filter enables physical handling per high local node.
// RQ7: physical requests pass the asynchronous filter, then the physical filter.
// RQ8: clear physical bit sends the request to the async receive request context.
// RQ9: node comparison is done only for sources on the local bus.
// RQ10: remote-bus packets are not acknowledged unless physical bit 31 is set.
// RQ11: physical bit 31 set accepts all requests from remote buses.
// RQ12: physical bit 31 survives host bus reset; other bits reset normally.
// RQ13: physical bits 30 to 19 map to nodes 62 to 51.
// RQ14: physical high filter sits at set alias 110h, read/set/clear.
// RQ15: physical bits 18 to 0 map to nodes 50 to 32.
// RQ16: high asynchronous bits 30 to 0 map nodes 62 to 32; bit 31 remote (not read here; physical bit 31 decides remote acceptance).
// RQ17: ones written set or clear bits; zeros ignored; both aliases read value.
// RQ18: physical high filter has its clear alias at 114h.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

`include "request_filter_regs.svh"

module request_node_filter
    import request_filter_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        power_on_rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    input  wire logic        req_valid,
    input  wire bus_id_t     req_src_bus,
    input  wire node_id_t    req_src_node,
    input  wire logic        req_is_phys,
    input  wire logic [31:0] async_high_filter,
    input  wire logic [31:0] phys_low_filter,
    output logic      [31:0] async_low_filter,
    output logic      [31:0] phys_high_filter,
    output logic             dec_valid,
    output route_t           dec_route,
    output logic             dec_ack,
    output node_id_t         dec_src_node
);

    // ----------------------------------------------------------------------------
    // saturating event counter step; a clear in the same cycle as an event keeps the event
    // ----------------------------------------------------------------------------
    function automatic logic [`STAT_CNT_W-1:0] cnt_step(input logic [`STAT_CNT_W-1:0] cnt,
                                                      input logic event_hit,
                                                      input logic clear);
        if (clear) begin
            cnt_step = event_hit ? `STAT_CNT_ONE : `STAT_CNT_ZERO;
        end else if (event_hit && (cnt != `STAT_CNT_MAX)) begin
            cnt_step = cnt + `STAT_CNT_ONE;
        end else begin
            cnt_step = cnt;
        end
    endfunction

    // ----------------------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic hit_async_set;
    logic hit_async_clr;
    logic hit_phys_set;
    logic hit_phys_clr;
    logic hit_stats;
    logic hit_last;
    logic hit_bus_num;
    logic addr_hit;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_access    = access_phase && pwrite;

    assign hit_async_set = (paddr == `ASYNC_LOW_SET_OFS);      // RQ3
    assign hit_async_clr = (paddr == `ASYNC_LOW_CLR_OFS);      // RQ3
    assign hit_phys_set  = (paddr == `PHYS_HIGH_SET_OFS);      // RQ14
    assign hit_phys_clr  = (paddr == `PHYS_HIGH_CLR_OFS);      // RQ18
    assign hit_stats     = (paddr == `REQ_STATS_OFS);
    assign hit_last      = (paddr == `LAST_REQ_OFS);
    assign hit_bus_num   = (paddr == `BUS_NUMBER_OFS);
    assign addr_hit      = hit_async_set || hit_async_clr || hit_phys_set || hit_phys_clr ||
                           hit_stats || hit_last || hit_bus_num;

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access_phase && !addr_hit;

    // ----------------------------------------------------------------------------
    // filter words
    // ----------------------------------------------------------------------------
    logic [31:0] async_low_value;
    logic [31:0] phys_high_value;

    rsc_filter_reg #(
        .WIDTH     (32),
        .RESET_VAL (`FILTER_RESET),
        .KEEP_MASK (`FILTER_RESET)
    ) u_async_low (
        .clk    (pclk),
        .rst_n  (presetn),
        .por_n  (power_on_rst_n),
        .set_we (wr_access && hit_async_set),                  // RQ1 RQ17
        .clr_we (wr_access && hit_async_clr),                  // RQ17
        .wdata  (pwdata),
        .value  (async_low_value)
    );

    // the remote-buses bit rides on power-on reset so a host bus reset leaves it alone
    rsc_filter_reg #(
        .WIDTH     (32),
        .RESET_VAL (`FILTER_RESET),
        .KEEP_MASK (`KEEP_ON_BUS_RESET)
    ) u_phys_high (
        .clk    (pclk),
        .rst_n  (presetn),
        .por_n  (power_on_rst_n),
        .set_we (wr_access && hit_phys_set),                   // RQ6 RQ14
        .clr_we (wr_access && hit_phys_clr),                   // RQ18
        .wdata  (pwdata),
        .value  (phys_high_value)
    );

    assign async_low_filter = async_low_value;
    assign phys_high_filter = phys_high_value;

    // ----------------------------------------------------------------------------
    // local bus number, steers the local/remote split
    // ----------------------------------------------------------------------------
    bus_id_t bus_number_ff;
    bus_id_t nxt_bus_number;

    assign nxt_bus_number = (wr_access && hit_bus_num) ? pwdata[9:0] : bus_number_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_number_ff <= `BUS_NUMBER_RESET;
        end else begin
            bus_number_ff <= nxt_bus_number;
        end
    end

    // ----------------------------------------------------------------------------
    // request decision
    // ----------------------------------------------------------------------------
    route_t comb_route;
    logic   comb_local;
    logic   comb_ack;

    node_filter_decide u_decide (
        .async_low  (async_low_value),
        .async_high (async_high_filter),
        .phys_low   (phys_low_filter),
        .phys_high  (phys_high_value),
        .src_bus    (req_src_bus),
        .src_node   (req_src_node),
        .local_bus  (bus_number_ff),
        .is_phys    (req_is_phys),
        .route      (comb_route),
        .is_local   (comb_local),
        .ack        (comb_ack)
    );

    logic     dec_valid_ff;
    route_t   dec_route_ff;
    logic     dec_ack_ff;
    node_id_t dec_node_ff;
    logic     dec_local_ff;
    bus_id_t  dec_bus_ff;
    logic     [2:0] last_grant_ff;
    route_t   nxt_dec_route;
    logic     nxt_dec_ack;

    // an idle cycle shows a drop without ack so the outputs never hold stale grants
    assign nxt_dec_route = req_valid ? comb_route : ROUTE_DROP;   // RQ7 RQ8
    assign nxt_dec_ack   = req_valid && comb_ack;                 // RQ10

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_valid_ff <= 1'b0;
            dec_route_ff <= ROUTE_DROP;
            dec_ack_ff   <= 1'b0;
        end else begin
            dec_valid_ff <= req_valid;
            dec_route_ff <= nxt_dec_route;
            dec_ack_ff   <= nxt_dec_ack;
        end
    end

    // source of the most recent request, held until the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_node_ff  <= 6'h00;
            dec_local_ff <= 1'b0;
            dec_bus_ff   <= 10'h000;
            last_grant_ff <= 3'b000;
        end else if (req_valid) begin
            dec_node_ff  <= req_src_node;
            dec_local_ff <= comb_local;
            dec_bus_ff   <= req_src_bus;
            // ack and route kept here too, the pulse copies are gone before software can read them
            last_grant_ff <= {comb_ack, comb_route};
        end
    end

    assign dec_valid    = dec_valid_ff;
    assign dec_route    = dec_route_ff;
    assign dec_ack      = dec_ack_ff;
    assign dec_src_node = dec_node_ff;

    // ----------------------------------------------------------------------------
    // request statistics, cleared by any write to the stats word
    // ----------------------------------------------------------------------------
    logic [`STAT_CNT_W-1:0] async_cnt_ff;
    logic [`STAT_CNT_W-1:0] phys_cnt_ff;
    logic [`STAT_CNT_W-1:0] drop_cnt_ff;
    logic [`STAT_CNT_W-1:0] nxt_async_cnt;
    logic [`STAT_CNT_W-1:0] nxt_phys_cnt;
    logic [`STAT_CNT_W-1:0] nxt_drop_cnt;
    logic                   stats_clear;
    logic                   ev_async;
    logic                   ev_phys;
    logic                   ev_drop;

    assign stats_clear = wr_access && hit_stats;
    assign ev_async    = dec_valid_ff && (dec_route_ff == ROUTE_ASYNC);
    assign ev_phys     = dec_valid_ff && (dec_route_ff == ROUTE_PHYS);
    assign ev_drop     = dec_valid_ff && (dec_route_ff == ROUTE_DROP);

    assign nxt_async_cnt = cnt_step(async_cnt_ff, ev_async, stats_clear);
    assign nxt_phys_cnt  = cnt_step(phys_cnt_ff, ev_phys, stats_clear);
    assign nxt_drop_cnt  = cnt_step(drop_cnt_ff, ev_drop, stats_clear);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_cnt_ff <= `STAT_CNT_ZERO;
            phys_cnt_ff  <= `STAT_CNT_ZERO;
            drop_cnt_ff  <= `STAT_CNT_ZERO;
        end else begin
            async_cnt_ff <= nxt_async_cnt;
            phys_cnt_ff  <= nxt_phys_cnt;
            drop_cnt_ff  <= nxt_drop_cnt;
        end
    end

    // ----------------------------------------------------------------------------
    // read data, captured in the setup cycle so prdata comes from a flop
    // ----------------------------------------------------------------------------
    logic [31:0] stats_word;
    logic [31:0] last_word;
    logic [31:0] bus_word;
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    assign stats_word = {8'h00, drop_cnt_ff, phys_cnt_ff, async_cnt_ff};
    assign last_word  = {11'h000, last_grant_ff, dec_local_ff,
                         dec_bus_ff, 1'b0, dec_node_ff};
    assign bus_word   = {22'h00_0000, bus_number_ff};

    assign rd_mux = (hit_async_set || hit_async_clr) ? async_low_value :   // RQ17
                    (hit_phys_set || hit_phys_clr)   ? phys_high_value :   // RQ17
                    hit_stats                        ? stats_word :
                    hit_last                         ? last_word :
                    hit_bus_num                      ? bus_word :
                    32'h0000_0000;

    assign nxt_prdata = (setup_phase && !pwrite) ? rd_mux : prdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

endmodule

`default_nettype wire

// ==== tb/request_node_filter_checker.sv ====
// assertions on the ports of the request node filter
`timescale 1ns/1ps
`default_nettype none
`include "request_filter_regs.svh"

module request_node_filter_checker
    import request_filter_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        req_valid,
    input wire bus_id_t     req_src_bus,
    input wire node_id_t    req_src_node,
    input wire logic        req_is_phys,
    input wire logic [31:0] async_low_filter,
    input wire logic [31:0] phys_high_filter,
    input wire logic        dec_valid,
    input wire route_t      dec_route,
    input wire logic        dec_ack
);
    logic mapped;
    logic lo_hit_ff;

    assign mapped = paddr inside {`ASYNC_LOW_SET_OFS, `ASYNC_LOW_CLR_OFS, `PHYS_HIGH_SET_OFS,
                                  `PHYS_HIGH_CLR_OFS, `REQ_STATS_OFS, `LAST_REQ_OFS, `BUS_NUMBER_OFS};

    // filter bit seen by the request, so the decision one cycle later can be judged
    always_ff @(posedge pclk) begin
        lo_hit_ff <= async_low_filter[req_src_node[4:0]];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    sequence s_local_low;
        req_valid && req_src_bus == 10'h3ff && req_src_node < 6'd32;
    endsequence

    AST_LOW_SET: assert property (s_wr(`ASYNC_LOW_SET_OFS) |=>
        async_low_filter == ($past(async_low_filter) | $past(pwdata))) else $error("low set alias wrong");
    AST_LOW_CLR: assert property (s_wr(`ASYNC_LOW_CLR_OFS) |=>
        async_low_filter == ($past(async_low_filter) & ~$past(pwdata))) else $error("low clear alias wrong");
    AST_PHYS_SET: assert property (s_wr(`PHYS_HIGH_SET_OFS) |=>
        phys_high_filter == ($past(phys_high_filter) | $past(pwdata))) else $error("phys set alias wrong");
    AST_LOW_HOLD: assert property (!(psel && penable && pwrite && paddr[11:3] == 9'h021) |=>
        $stable(async_low_filter)) else $error("low filter changed without write");
    AST_DEC_PULSE: assert property (req_valid |=> dec_valid)
        else $error("no decision after request");
    AST_DEC_IDLE: assert property (!req_valid |=> !dec_valid && dec_route == ROUTE_DROP && !dec_ack)
        else $error("decision without request");
    AST_LOW_ACK: assert property (s_local_low |=> dec_ack == lo_hit_ff)
        else $error("low node acceptance wrong");
    AST_REMOTE: assert property (req_valid && req_src_bus != 10'h3ff |=>
        dec_ack == $past(phys_high_filter[31])) else $error("remote acceptance wrong");
    AST_NO_PHYS: assert property (req_valid && !req_is_phys |=> dec_route != ROUTE_PHYS)
        else $error("non physical request routed physical");
    AST_ERR: assert property (pslverr == (psel && penable && !mapped))
        else $error("error response wrong");
    AST_RST_CLEAR: assert property ($rose(presetn) |->
        async_low_filter == 32'h0 && phys_high_filter[30:0] == 31'h0) else $error("filters not cleared");
endmodule

bind request_node_filter request_node_filter_checker u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .req_valid, .req_src_bus, .req_src_node, .req_is_phys, .async_low_filter,
    .phys_high_filter, .dec_valid, .dec_route, .dec_ack
);
`default_nettype wire

// ==== tb/remote_node_model.sv ====
// model of the remote bus nodes that send requests to the filter
`timescale 1ns/1ps
`default_nettype none

module remote_node_model
    import request_filter_pkg::*;
(
    input  wire logic pclk,
    output logic      req_valid,
    output bus_id_t   req_src_bus,
    output node_id_t  req_src_node,
    output logic      req_is_phys
);
    initial begin
        req_valid    = 1'b0;
        req_src_bus  = 10'h155;
        req_src_node = 6'h2a;
        req_is_phys  = 1'b0;
    end

    task automatic send(input bus_id_t b, input node_id_t n, input logic p);
        @(posedge pclk);
        req_valid    <= 1'b1;
        req_src_bus  <= b;
        req_src_node <= n;
        req_is_phys  <= p;
        @(posedge pclk);
        req_valid    <= 1'b0;
        // stale fields inverted so nothing leans on them after the strobe
        req_src_bus  <= ~b;
        req_src_node <= ~n;
        req_is_phys  <= ~p;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_request_node_filter.sv ====
// self-checking testbench of the request node filter
`timescale 1ns/1ps
`default_nettype none
`include "request_filter_regs.svh"

module test_request_node_filter
    import request_filter_pkg::*;
;
    logic        pclk, presetn, power_on_rst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ahi, plo, lo_m, ph_m, rd, async_low_filter, phys_high_filter;
    logic        pready, pslverr, req_valid, req_is_phys, dec_valid, dec_ack, err;
    bus_id_t     req_src_bus;
    node_id_t    req_src_node, dec_src_node;
    route_t      dec_route;
    int          n_mismatch, n_tests;
    logic [11:0] ofs [4] = '{`ASYNC_LOW_SET_OFS, `ASYNC_LOW_CLR_OFS, `PHYS_HIGH_SET_OFS, `PHYS_HIGH_CLR_OFS};
    node_id_t    nodes [8] = '{6'd0, 6'd5, 6'd1, 6'd31, 6'd32, 6'd40, 6'd62, 6'd63};

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    request_node_filter u_dut (
        .pclk(pclk), .presetn(presetn), .power_on_rst_n(power_on_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .req_valid(req_valid), .req_src_bus(req_src_bus), .req_src_node(req_src_node),
        .req_is_phys(req_is_phys), .async_high_filter(ahi), .phys_low_filter(plo),
        .async_low_filter(async_low_filter), .phys_high_filter(phys_high_filter), .dec_valid(dec_valid),
        .dec_route(dec_route), .dec_ack(dec_ack), .dec_src_node(dec_src_node)
    );

    remote_node_model u_node (
        .pclk(pclk), .req_valid(req_valid), .req_src_bus(req_src_bus),
        .req_src_node(req_src_node), .req_is_phys(req_is_phys)
    );

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; shadow filters follow the set and clear aliases
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (w) begin
            case (a)
                `ASYNC_LOW_SET_OFS: lo_m = lo_m | d;
                `ASYNC_LOW_CLR_OFS: lo_m = lo_m & ~d;
                `PHYS_HIGH_SET_OFS: ph_m = ph_m | d;
                `PHYS_HIGH_CLR_OFS: ph_m = ph_m & ~d;
                default: ;
            endcase
        end
    endtask

    task automatic read_all();
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, ofs[i][4] ? ph_m : lo_m);
        end
    endtask

    function automatic logic [2:0] exp_dec(input bus_id_t b, input node_id_t n, input logic p);
        logic acc;
        logic pb;
        acc = ph_m[31];
        pb = ph_m[31];
        if (b == 10'h3ff) begin
            acc = (n < 6'd32) ? lo_m[n[4:0]] : (n == 6'd63) ? 1'b0 : ahi[n[4:0]];
            pb = (n < 6'd32) ? plo[n[4:0]] : ph_m[n[4:0]];
        end
        return {acc, !acc ? 2'b00 : (p && pb) ? 2'b10 : 2'b01};
    endfunction

    task automatic req(input bus_id_t b, input node_id_t n, input logic p);
        logic [2:0] e;
        e = exp_dec(b, n, p);
        u_node.send(b, n, p);
        #1;
        chk({dec_valid, dec_ack, dec_route, dec_src_node}, {1'b1, e, n});
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        power_on_rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ahi = 32'h4000_0101;
        plo = 32'h0000_0021;
        lo_m = 32'h0;
        ph_m = 32'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        power_on_rst_n <= 1'b1;
        read_all();
        $display("reset values test done");

        apb(1'b1, `ASYNC_LOW_SET_OFS, 32'ha5a5_0f0f);
        apb(1'b1, `ASYNC_LOW_SET_OFS, 32'h0000_00f0);
        apb(1'b1, `ASYNC_LOW_CLR_OFS, 32'h8000_0005);
        apb(1'b1, `PHYS_HIGH_SET_OFS, 32'h8008_0001);
        apb(1'b1, `PHYS_HIGH_CLR_OFS, 32'h0000_0001);
        read_all();
        apb(1'b1, 12'h200, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b0, 12'h200, 32'h0);
        chk({err, rd[30:0]}, {1'b1, 31'h0});
        read_all();
        $display("set clear alias test done");

        apb(1'b1, `ASYNC_LOW_CLR_OFS, 32'hffff_ffff);
        apb(1'b1, `ASYNC_LOW_SET_OFS, 32'h8000_0021);
        apb(1'b1, `PHYS_HIGH_CLR_OFS, 32'hffff_ffff);
        apb(1'b1, `PHYS_HIGH_SET_OFS, 32'h4000_0001);
        foreach (nodes[i]) begin
            req(10'h3ff, nodes[i], i != 1);
        end
        req(10'h012, 6'd3, 1'b1);
        apb(1'b1, `PHYS_HIGH_SET_OFS, 32'h8000_0000);
        req(10'h012, 6'd3, 1'b1);
        req(10'h3ff, 6'd1, 1'b1);
        apb(1'b0, `REQ_STATS_OFS, 32'h0);
        chk(rd, 32'h0004_0403);
        $display("request routing test done");

        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        lo_m = 32'h0;
        ph_m = ph_m & 32'h8000_0000;
        read_all();
        req(10'h012, 6'd7, 1'b0);
        apb(1'b0, `LAST_REQ_OFS, 32'h0);
        chk(rd, 32'h0014_0907);
        $display("bus reset test done");
        complete_run();
    end
endmodule
`default_nettype wire
